// File: adc_port_cfg.svh
// offsets, field positions, reset values and timing counts of the conversion port
// assumes a 100 MHz core clock and a 32-bit classic wishbone register bus
`ifndef ADC_PORT_CFG_SVH
`define ADC_PORT_CFG_SVH

// ****************************************************************
// register byte offsets
// ****************************************************************
`define CTRL_OFS 8'h00
`define STATUS_OFS 8'h04
`define RESULT_OFS 8'h08

// ****************************************************************
// register fields and reset values
// ****************************************************************
`define CTRL_RES16_BIT 0
`define CTRL_RESET 1'b1
`define STAT_BUSY_BIT 0
`define STAT_SLEEP_BIT 1
`define STAT_FRAME_BIT 2
`define STAT_CFG_LSB 8
`define STAT_CFG_MSB 14

// ****************************************************************
// configuration word, first bit sent lands at the top
// ****************************************************************
`define CFG_WIDTH 7
`define CFG_SD_BIT 6
`define CFG_OS_BIT 5
`define CFG_S1_BIT 4
`define CFG_S0_BIT 3
`define CFG_COM_BIT 2
`define CFG_UNI_BIT 1
`define CFG_SLP_BIT 0
`define CFG_RESET 7'h42
`define CFG_COUNT_FULL 3'h7

// ****************************************************************
// result and timing
// ****************************************************************
`define RESULT_WIDTH 16
`define RES12_MASK 16'hFFF0
`define CONV_TIME_NS 3200
`define CLK_PERIOD_NS 10
`define SAR_STEP_CYCLES (`CONV_TIME_NS / `CLK_PERIOD_NS / `RESULT_WIDTH)
`define SYNC_SETTLE 2'h3

`endif

// File: adc_port_pkg.sv
// types shared by the conversion port and its successive-approximation engine
// assumes nothing of its surroundings
package adc_port_pkg;

  typedef enum logic [1:0] {
    PORT_ACQ = 2'h1,
    PORT_CONV = 2'h2
  } port_state_t;

  typedef enum logic [1:0] {
    SAR_IDLE = 2'h1,
    SAR_RUN = 2'h2
  } sar_state_t;

  typedef enum logic [1:0] {
    NEG_GND = 2'h0,
    NEG_CH = 2'h1,
    NEG_COM = 2'h2
  } neg_src_t;

endpackage

// File: adc_serial_conversion_port.sv
// conversion control and serial port of an 8-channel successive-approximation converter
// assumes frame, shift clock and serial input come asynchronously from a host controller,
// the comparator decision comes on clk_i, and software reaches the registers over wishbone
//
// Operation
// - a rising frame edge starts a new conversion
// - start attempts during a conversion are ignored; the conversion runs to its end
// - the frame line both starts conversions and bounds each serial transfer
// - between conversions take the next word, shift out the result, acquire input
// - result bits are decided from msb down to lsb
// - the finished 12- or 16-bit result is latched for the next read
// - result leaves as straight binary unipolar, two's complement bipolar
// - host shifts the configuration word in during each framed transfer
// - seven-bit word: single/diff, odd/sign, addr hi, addr lo, common, polarity, sleep
// - polarity field picks unipolar or bipolar; sleep field puts converter to sleep
// - common field makes the last input an ordinary channel or the shared minus
// - the serial output moves to its next bit after each falling shift edge
// - the serial input is sampled on rising shift edges
// - a falling frame edge drives the serial output with its first bit
// - a rising frame edge releases the serial output
// - single-ended uses ground or common as minus; differential pairs, odd/sign swaps
// - with common set, the last pin is the minus input in every mode
//
// The address map and the Wishbone interface to the registers were decided locally.
`timescale 1ns/100ps
`include "adc_port_cfg.svh"
module adc_serial_conversion_port
  import adc_port_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [7:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  input wire logic conv_start_frame_i,
  input wire logic sck_i,
  input wire logic config_serial_in_i,
  output logic result_serial_out_o,
  output logic result_serial_out_oe_n_o,
  input wire logic comp_i,
  output logic [15:0] dac_trial_o,
  output logic acquire_o,
  output logic sleep_o,
  output logic unipolar_o,
  output logic [2:0] pos_ch_o,
  output logic [1:0] neg_src_o,
  output logic [2:0] neg_ch_o
);
  port_state_t state;
  logic frame_s;
  logic sck_s;
  logic sdi_s;
  logic frame_d;
  logic sck_d;
  logic frame_rise;
  logic frame_fall;
  logic sck_rise;
  logic sck_fall;
  logic [`CFG_WIDTH-1:0] cfg;
  logic [`CFG_WIDTH-1:0] in_shift;
  logic [2:0] in_cnt;
  logic [15:0] out_shift;
  logic [15:0] result_latch;
  logic [15:0] next_result;
  logic res16;
  logic wb_req;
  logic [1:0] settle_cnt;
  logic edges_ok;

  sar_if sar_bus ();

  // ****************************************************************
  // pin synchronisers and edge finding
  // ****************************************************************
  sync2 frame_sync (.clk_i(clk_i), .rst_i(rst_i), .d_i(conv_start_frame_i), .q_o(frame_s));
  sync2 sck_sync (.clk_i(clk_i), .rst_i(rst_i), .d_i(sck_i), .q_o(sck_s));
  sync2 sdi_sync (.clk_i(clk_i), .rst_i(rst_i), .d_i(config_serial_in_i), .q_o(sdi_s));

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      frame_d <= 1'b0;
      sck_d <= 1'b0;
    end else begin
      frame_d <= frame_s;
      sck_d <= sck_s;
    end
  end

  // synchronisers restart at zero, so the idle-high frame pin would look like a rise
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      settle_cnt <= 2'h0;
    end else if (settle_cnt != `SYNC_SETTLE) begin
      settle_cnt <= settle_cnt + 2'h1;
    end
  end

  assign edges_ok = (settle_cnt == `SYNC_SETTLE);
  assign frame_rise = frame_s & ~frame_d & edges_ok;
  assign frame_fall = ~frame_s & frame_d & edges_ok;
  assign sck_rise = sck_s & ~sck_d & ~frame_s & edges_ok;
  assign sck_fall = ~sck_s & sck_d & ~frame_s & edges_ok;

  // ****************************************************************
  // conversion control
  // ****************************************************************
  sar_engine engine (.clk_i(clk_i), .rst_i(rst_i), .comp_i(comp_i), .sar(sar_bus.engine));

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state <= PORT_ACQ;
    end else begin
      unique case (state)
        PORT_ACQ: if (frame_rise && !cfg[`CFG_SLP_BIT]) state <= PORT_CONV;
        PORT_CONV: if (sar_bus.done) state <= PORT_ACQ;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sar_bus.start <= 1'b0;
    end else begin
      // a rise while converting is dropped, not queued
      sar_bus.start <= frame_rise && state == PORT_ACQ && !cfg[`CFG_SLP_BIT];
    end
  end

  assign dac_trial_o = sar_bus.trial;

  always_comb begin
    next_result = res16 ? sar_bus.code : (sar_bus.code & `RES12_MASK);
    if (!cfg[`CFG_UNI_BIT]) begin
      next_result[15] = ~next_result[15];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      result_latch <= 16'h0000;
    end else if (sar_bus.done) begin
      result_latch <= next_result;
    end
  end

  // ****************************************************************
  // serial transfer
  // ****************************************************************
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      out_shift <= 16'h0000;
      result_serial_out_oe_n_o <= 1'b1;
    end else if (frame_rise) begin
      result_serial_out_oe_n_o <= 1'b1;
    end else if (frame_fall) begin
      out_shift <= result_latch;
      result_serial_out_oe_n_o <= 1'b0;
    end else if (sck_fall) begin
      out_shift <= {out_shift[14:0], 1'b0};
    end
  end

  assign result_serial_out_o = out_shift[15];

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      in_shift <= 7'h00;
      in_cnt <= 3'h0;
    end else if (frame_fall) begin
      in_cnt <= 3'h0;
    end else if (sck_rise) begin
      in_shift <= {in_shift[`CFG_WIDTH-2:0], sdi_s};
      if (in_cnt != `CFG_COUNT_FULL) begin
        in_cnt <= in_cnt + 3'h1;
      end
    end
  end

  // a short word leaves the previous setting in force
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cfg <= `CFG_RESET;
    end else if (frame_rise && in_cnt == `CFG_COUNT_FULL) begin
      cfg <= in_shift;
    end
  end

  // ****************************************************************
  // multiplexer and mode outputs
  // ****************************************************************
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pos_ch_o <= 3'h0;
      neg_ch_o <= 3'h0;
      neg_src_o <= NEG_GND;
    end else begin
      // plus channel is coded alike in single-ended and differential modes
      pos_ch_o <= {cfg[`CFG_S1_BIT], cfg[`CFG_S0_BIT], cfg[`CFG_OS_BIT]};
      neg_ch_o <= {cfg[`CFG_S1_BIT], cfg[`CFG_S0_BIT], ~cfg[`CFG_OS_BIT]};
      if (cfg[`CFG_COM_BIT]) begin
        neg_src_o <= NEG_COM;
      end else if (cfg[`CFG_SD_BIT]) begin
        neg_src_o <= NEG_GND;
      end else begin
        neg_src_o <= NEG_CH;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sleep_o <= 1'b0;
      unipolar_o <= 1'b1;
      acquire_o <= 1'b0;
    end else begin
      sleep_o <= cfg[`CFG_SLP_BIT];
      unipolar_o <= cfg[`CFG_UNI_BIT];
      acquire_o <= (state == PORT_ACQ) && !cfg[`CFG_SLP_BIT];
    end
  end

  // ****************************************************************
  // wishbone slave
  // ****************************************************************
  assign wb_req = cyc_i & stb_i & ~ack_o;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      res16 <= `CTRL_RESET;
    end else if (wb_req && we_i && sel_i[0] && adr_i == `CTRL_OFS) begin
      res16 <= dat_i[`CTRL_RES16_BIT];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
      dat_o <= 32'h00000000;
    end else begin
      ack_o <= wb_req;
      dat_o <= 32'h00000000;
      if (wb_req && !we_i) begin
        case (adr_i)
          `CTRL_OFS: dat_o[`CTRL_RES16_BIT] <= res16;
          `STATUS_OFS: begin
            dat_o[`STAT_BUSY_BIT] <= (state == PORT_CONV);
            dat_o[`STAT_SLEEP_BIT] <= cfg[`CFG_SLP_BIT];
            dat_o[`STAT_FRAME_BIT] <= ~frame_s;
            dat_o[`STAT_CFG_MSB:`STAT_CFG_LSB] <= cfg;
          end
          `RESULT_OFS: dat_o[15:0] <= result_latch;
          default: dat_o <= 32'h00000000;
        endcase
      end
    end
  end

  // ****************************************************************
  // checks
  // ****************************************************************
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence frame_fall_s;
    frame_fall;
  endsequence
  sequence sdo_driven_s;
    !result_serial_out_oe_n_o ##1 !result_serial_out_oe_n_o;
  endsequence

  start_on_rise_a: assert property (
    (frame_rise && state == PORT_ACQ && !cfg[`CFG_SLP_BIT]) |-> ##2 sar_bus.busy)
    else $error("rising frame did not start a conversion");
  no_restart_a: assert property (
    (sar_bus.busy && frame_rise) |=> !sar_bus.start ##1 !sar_bus.start)
    else $error("conversion restarted while busy");
  latch_unipolar_a: assert property (
    (sar_bus.done && cfg[`CFG_UNI_BIT]) |=> result_latch[15:4] == $past(sar_bus.code[15:4]))
    else $error("result latch not loaded at conversion end");
  bipolar_msb_a: assert property (
    (sar_bus.done && !cfg[`CFG_UNI_BIT]) |=> result_latch[15] != $past(sar_bus.code[15]))
    else $error("bipolar result not in two's complement");
  first_bit_a: assert property (
    frame_fall_s |=> sdo_driven_s and (result_serial_out_o == $past(result_latch[15])))
    else $error("first result bit not driven after frame fall");
  sdo_release_a: assert property (
    frame_rise |=> result_serial_out_oe_n_o)
    else $error("serial output not released after frame rise");
  sdo_shift_a: assert property (
    (sck_fall && !frame_rise && !frame_fall) |=> result_serial_out_o == $past(out_shift[14]))
    else $error("serial output did not advance on falling shift edge");
  cfg_sample_a: assert property (
    (sck_rise && !frame_fall) |=> in_shift[0] == $past(sdi_s))
    else $error("serial input not sampled on rising shift edge");
  common_minus_a: assert property (
    cfg[`CFG_COM_BIT] |=> neg_src_o == NEG_COM)
    else $error("common pin not selected as minus input");
  single_gnd_a: assert property (
    (cfg[`CFG_SD_BIT] && !cfg[`CFG_COM_BIT]) |=> neg_src_o == NEG_GND &&
      pos_ch_o[2:1] == $past(cfg[`CFG_S1_BIT:`CFG_S0_BIT]) &&
      pos_ch_o[0] == $past(cfg[`CFG_OS_BIT]))
    else $error("single-ended selection decoded wrongly");
  no_start_asleep_a: assert property (
    (frame_rise && cfg[`CFG_SLP_BIT]) |=> !sar_bus.start)
    else $error("conversion started while asleep");
  sdo_hold_a: assert property (
    (!sck_fall && !frame_fall) |=> $stable(result_serial_out_o))
    else $error("serial output moved without a falling shift edge");
endmodule

// File: adc_serial_conversion_port_tb.sv
// self-checking bench of the conversion port: wishbone master, comparator model, host model
// assumes the host model file is compiled first and a 100 MHz core clock
`timescale 1ns/100ps
`include "adc_port_cfg.svh"
module adc_serial_conversion_port_tb import adc_port_pkg::*; ();
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc_i = 1'b0;
  logic stb_i = 1'b0;
  logic we_i = 1'b0;
  logic [7:0] adr_i = 8'h00;
  logic [3:0] sel_i = 4'h0;
  logic [31:0] dat_i = 32'h0;
  logic comp_i = 1'b0;
  logic [31:0] dat_o, rd;
  logic ack_o, conv_start_frame, sck, config_serial_in, result_serial_out, oe_n, acquire_o, sleep_o, unipolar_o;
  logic [15:0] dac_trial_o;
  logic [15:0] res_q[$];
  logic [15:0] ain = 16'h0000;
  logic [2:0] pos_ch_o, neg_ch_o;
  logic [1:0] neg_src_o;
  logic asleep = 1'b0;
  logic res16 = 1'b1;
  wire sdo_line;
  int error_cnt = 0;
  int tests_run = 0;

  always #5 clk_i = ~clk_i;
  // no pull on the line: a released output reads as the inverse of its last bit
  assign sdo_line = oe_n ? ~result_serial_out : result_serial_out;
  // comparator of an ideal converter holding ain
  always @(posedge clk_i) comp_i <= (ain >= dac_trial_o);

  adc_serial_conversion_port adc_serial_conversion_port_inst (.clk_i(clk_i), .rst_i(rst_i),
    .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i),
    .dat_o(dat_o), .ack_o(ack_o), .conv_start_frame_i(conv_start_frame), .sck_i(sck),
    .config_serial_in_i(config_serial_in), .result_serial_out_o(result_serial_out), .result_serial_out_oe_n_o(oe_n),
    .comp_i(comp_i), .dac_trial_o(dac_trial_o), .acquire_o(acquire_o), .sleep_o(sleep_o),
    .unipolar_o(unipolar_o), .pos_ch_o(pos_ch_o), .neg_src_o(neg_src_o), .neg_ch_o(neg_ch_o));
  host_model host_model_inst (.frame_o(conv_start_frame), .sck_o(sck), .sdi_o(config_serial_in),
    .sdo_i(sdo_line), .sdo_oe_n_i(oe_n));

  // ****************************************************************
  // compare, verdict and bus tasks
  // ****************************************************************
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic chk_bit(input string what, input logic exp, input logic got);
    tests_run++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error %s expected %b seen %b", what, exp, got);
    end
  endtask
  task automatic wrap_up();
    if (error_cnt == 0 && tests_run > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic wb(input logic w, input logic [7:0] a, input logic [3:0] s,
    input logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= a;
    sel_i <= s;
    dat_i <= d;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack_o !== 1'b1 && n < 20);
    if (n >= 20) begin
      error_cnt++;
      wrap_up();
    end else begin
      q = dat_o;
      cyc_i <= 1'b0;
      stb_i <= 1'b0;
      we_i <= 1'b0;
    end
  endtask

  // ****************************************************************
  // one frame: read old result, load word, convert, check outputs
  // ****************************************************************
  task automatic frame(input logic [6:0] cfg, input logic glitch);
    logic [15:0] got, exp, dmy;
    logic oi, oo, conv;
    neg_src_t ns;
    real t0;
    int cnt, cyc;
    conv = !asleep;
    ain <= 16'($urandom);
    @(posedge clk_i);
    #1.3;
    host_model_inst.xfer(cfg, 16, got, oi, oo);
    t0 = $realtime;
    if (res_q.size() > 0) chk("serial result", 32'(res_q[$]), 32'(got));
    chk_bit("oe in frame", 1'b0, oi);
    chk_bit("oe after frame", 1'b1, oo);
    exp = cfg[1] ? ain : ain ^ 16'h8000;
    if (!res16) exp = exp & `RES12_MASK;
    if (glitch) begin
      repeat (100) @(posedge clk_i);
      #1.3;
      host_model_inst.xfer(7'h7F, 3, dmy, oi, oo);
    end
    cnt = 0;
    if (conv) begin
      do begin
        wb(1'b0, `STATUS_OFS, 4'hF, 32'h0, rd);
        cnt++;
      end while (rd[`STAT_BUSY_BIT] !== 1'b0 && cnt < 300);
      cyc = int'(($realtime - t0 + 162.5) / 10.0);
      chk_bit("conversion length", 1'b1, cyc >= 318 && cyc <= 345);
      wb(1'b0, `RESULT_OFS, 4'hF, 32'h0, rd);
      chk("result reg", 32'(exp), 32'(rd[15:0]));
      res_q.push_back(exp);
    end else begin
      repeat (10) @(posedge clk_i);
    end
    if (cnt >= 300) begin
      error_cnt++;
      wrap_up();
    end else begin
      wb(1'b0, `STATUS_OFS, 4'hF, 32'h0, rd);
      chk_bit("busy", 1'b0, rd[`STAT_BUSY_BIT]);
      chk("status word", 32'(cfg), 32'(rd[14:8]));
      ns = cfg[2] ? NEG_COM : (cfg[6] ? NEG_GND : NEG_CH);
      chk("plus channel", 32'({cfg[4], cfg[3], cfg[5]}), 32'(pos_ch_o));
      chk("minus source", 32'(ns), 32'(neg_src_o));
      if (ns == NEG_CH) begin
        chk("minus channel", 32'({cfg[4], cfg[3], ~cfg[5]}), 32'(neg_ch_o));
      end
      chk_bit("unipolar", cfg[1], unipolar_o);
      chk_bit("sleep", cfg[0], sleep_o);
      chk_bit("acquire", ~cfg[0], acquire_o);
      asleep = cfg[0];
      repeat (201) @(posedge clk_i);
    end
  endtask

  // ****************************************************************
  // main sequence and watchdog
  // ****************************************************************
  initial begin
    void'($urandom(57));
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (3) @(posedge clk_i);
    wb(1'b0, `CTRL_OFS, 4'hF, 32'h0, rd);
    chk_bit("ctrl reset", 1'b1, rd[0]);
    wb(1'b0, `STATUS_OFS, 4'hF, 32'h0, rd);
    chk("status reset", 32'(7'h42), 32'(rd[14:8]));
    wb(1'b0, 8'h0C, 4'hF, 32'h0, rd);
    chk("unmapped read", 32'h0, rd);
    for (int i = 0; i < 32; i++) begin
      if (i == 16) begin
        wb(1'b1, `CTRL_OFS, 4'hE, 32'h0, rd);
        wb(1'b0, `CTRL_OFS, 4'hF, 32'h0, rd);
        chk_bit("ctrl masked write", 1'b1, rd[0]);
        wb(1'b1, `CTRL_OFS, 4'h1, 32'h0, rd);
        res16 = 1'b0;
        wb(1'b0, `CTRL_OFS, 4'hF, 32'h0, rd);
        chk_bit("ctrl write", 1'b0, rd[0]);
      end
      frame({i[4:0], 1'($urandom), 1'b0}, i == 5);
    end
    // sleep word converts once; frames while asleep start nothing
    frame(7'h41, 1'b0);
    frame(7'h41, 1'b0);
    frame(7'h42, 1'b0);
    // the ideal comparator model needs no wake-up time after sleep
    frame(7'h42, 1'b0);
    wrap_up();
  end
  initial begin
    #800us;
    error_cnt++;
    wrap_up();
  end
endmodule

// File: host_model.sv
// serial host controller model: drives frame, shift clock and config input
// assumes a 125 ns shift clock that stands still outside frames, released output reads inverted
`timescale 1ns/100ps
module host_model (
  output logic frame_o,
  output logic sck_o,
  output logic sdi_o,
  input wire logic sdo_i,
  input wire logic sdo_oe_n_i
);
  initial begin
    frame_o = 1'b1;
    sck_o = 1'b0;
    sdi_o = 1'b0;
  end
  // ****************************************************************
  // one framed transfer, config word in the last seven shifts
  // ****************************************************************
  task automatic xfer(input logic [6:0] cfg, input int n, output logic [15:0] rd,
    output logic oe_in, output logic oe_out);
    logic b;
    rd = 16'h0000;
    b = 1'b0;
    frame_o = 1'b0;
    #62.5;
    oe_in = sdo_oe_n_i;
    for (int i = n - 1; i >= 0; i--) begin
      b = (i < 7) ? cfg[i] : 1'($urandom);
      sdi_o = b;
      #62.5;
      sck_o = 1'b1;
      rd = {rd[14:0], sdo_i};
      #62.5;
      sck_o = 1'b0;
    end
    // input hold has run out: show the inverse, not the last bit
    sdi_o = ~b;
    #62.5;
    frame_o = 1'b1;
    #100;
    oe_out = sdo_oe_n_i;
    #62.5;
  endtask
endmodule

// File: sar_engine.sv
// successive-approximation sequencer: one trial bit per step, msb first
// assumes comp_i is the comparator decision, settled on clk_i, high when input >= trial
`timescale 1ns/100ps
`include "adc_port_cfg.svh"
module sar_engine
  import adc_port_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic comp_i,
  sar_if.engine sar
);
  localparam logic [7:0] STEP_LAST = 8'(`SAR_STEP_CYCLES - 1);

  sar_state_t state;
  logic [3:0] bit_idx;
  logic [7:0] step_cnt;
  logic [15:0] trial;
  logic [15:0] code;
  logic done;
  logic [15:0] mask;
  logic [15:0] decided;
  logic last_step;

  assign mask = 16'h0001 << bit_idx;
  assign decided = comp_i ? trial : (trial & ~mask);
  assign last_step = (step_cnt == STEP_LAST);
  assign sar.busy = (state == SAR_RUN);
  assign sar.trial = trial;
  assign sar.code = code;
  assign sar.done = done;

  // ****************************************************************
  // sequencing
  // ****************************************************************
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state <= SAR_IDLE;
    end else begin
      unique case (state)
        SAR_IDLE: if (sar.start) state <= SAR_RUN;
        SAR_RUN: if (last_step && bit_idx == 4'h0) state <= SAR_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      step_cnt <= 8'h00;
      bit_idx <= 4'hF;
    end else if (state == SAR_IDLE) begin
      step_cnt <= 8'h00;
      bit_idx <= 4'hF;
    end else if (last_step) begin
      step_cnt <= 8'h00;
      bit_idx <= bit_idx - 4'h1;
    end else begin
      step_cnt <= step_cnt + 8'h01;
    end
  end

  // ****************************************************************
  // bit decisions, msb to lsb
  // ****************************************************************
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      trial <= 16'h0000;
    end else if (state == SAR_IDLE && sar.start) begin
      trial <= 16'h8000;
    end else if (state == SAR_RUN && last_step) begin
      trial <= decided | (mask >> 1);
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      code <= 16'h0000;
      done <= 1'b0;
    end else begin
      done <= (state == SAR_RUN) && last_step && (bit_idx == 4'h0);
      if (state == SAR_RUN && last_step && bit_idx == 4'h0) begin
        code <= decided;
      end
    end
  end

  // ****************************************************************
  // checks
  // ****************************************************************
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  msb_trial_first_a: assert property (
    (state == SAR_IDLE && sar.start) |=> trial == 16'h8000 ##20 trial[14])
    else $error("first trial is not the msb alone");
  conv_length_a: assert property (
    $rose(sar.busy) |-> ##[320:320] done)
    else $error("conversion did not end after 320 cycles");
endmodule

// File: sar_if.sv
// signals between the port controller and the successive-approximation engine
// assumes both ends run on the same core clock
`timescale 1ns/100ps
interface sar_if;
  logic start;
  logic done;
  logic busy;
  logic [15:0] code;
  logic [15:0] trial;
  modport ctrl (output start, input done, busy, code, trial);
  modport engine (input start, output done, busy, code, trial);
endinterface

// File: sync2.sv
// two flip-flop synchroniser for one level
// assumes the input is asynchronous to clk_i
`timescale 1ns/100ps
module sync2 (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic d_i,
  output logic q_o
);
  logic meta;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      meta <= 1'b0;
      q_o <= 1'b0;
    end else begin
      meta <= d_i;
      q_o <= meta;
    end
  end
endmodule
